// *** design/alarm_pkg.sv ***
// shared types, register map and timing constants of the process alarm block
package alarm_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 250_000_000;
	localparam int unsigned EVAL_PERIOD_US = 1000;
	localparam int unsigned EVAL_CYCLES    = CLK_HZ / 1_000_000 * EVAL_PERIOD_US;
	localparam int unsigned EVALS_PER_SEC  = 1_000_000 / EVAL_PERIOD_US;
	localparam int unsigned DELAY_W        = 14;
	localparam int unsigned DCNT_W         = 24;
	localparam int unsigned NAME_WORDS     = 5;

	// ==========================================================
	// signal model
	typedef logic signed [31:0] analog_val_t;

	typedef enum logic [3:0] {
		ERR_NONE        = 4'h0,
		ERR_OPEN        = 4'h1,
		ERR_SHORTED     = 4'h2,
		ERR_MEASUREMENT = 4'h3,
		ERR_BAD_CAL     = 4'h4,
		ERR_AMBIENT     = 4'h5,
		ERR_RTD         = 4'h6,
		ERR_FAIL        = 4'h7,
		ERR_NOT_SOURCED = 4'h8,
		ERR_STALE       = 4'h9,
		ERR_MATH        = 4'ha
	} err_code_t;

	typedef enum logic [2:0] {
		UNIT_NONE      = 3'h0,
		UNIT_ABS_TEMP  = 3'h1,
		UNIT_REL_TEMP  = 3'h2,
		UNIT_HUMIDITY  = 3'h3,
		UNIT_POWER     = 3'h4,
		UNIT_PROCESS   = 3'h5
	} unit_t;

	typedef struct packed {
		analog_val_t value;
		unit_t       unit;
		err_code_t   err;
	} analog_sig_t;

	typedef struct packed {
		logic      on;
		err_code_t err;
	} digital_sig_t;

	localparam analog_val_t POWER_FULL = 32'sh0064_0000;
	localparam analog_val_t POWER_NONE = 32'sh0000_0000;

	// ==========================================================
	// configuration
	typedef enum logic [1:0] {
		ATYPE_OFF     = 2'h0,
		ATYPE_PROCESS = 2'h1
	} alarm_type_t;

	typedef enum logic [1:0] {
		SIDES_BOTH = 2'h0,
		SIDES_HIGH = 2'h1,
		SIDES_LOW  = 2'h2
	} sides_t;

	typedef struct packed {
		logic        dis_lvl;
		logic        clr_lvl;
		logic        sil_lvl;
		logic        open_on_alarm;
		logic        sil_en;
		logic        latch;
		sides_t      sides;
		alarm_type_t atype;
	} ctrl_t;

	typedef enum logic [2:0] {
		OUT_IDLE     = 3'b001,
		OUT_ACTIVE   = 3'b010,
		OUT_SILENCED = 3'b100
	} out_state_t;

	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_CMD       = 8'h04;
	localparam logic [7:0] ADDR_HIGH_SP   = 8'h08;
	localparam logic [7:0] ADDR_LOW_SP    = 8'h0c;
	localparam logic [7:0] ADDR_HYST      = 8'h10;
	localparam logic [7:0] ADDR_DELAY     = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;
	localparam logic [7:0] ADDR_INPUT     = 8'h1c;
	localparam logic [7:0] ADDR_NAME0     = 8'h20;
	localparam logic [7:0] ADDR_NAME_LAST = 8'h30;
	localparam int unsigned CMD_CLEAR_BIT   = 0;
	localparam int unsigned CMD_SILENCE_BIT = 1;

	localparam ctrl_t       CTRL_RST    = ctrl_t'(10'h380);
	localparam analog_val_t HIGH_SP_RST = 32'sh0064_0000;
	localparam analog_val_t LOW_SP_RST  = 32'sh0000_0000;
	localparam analog_val_t HYST_RST    = 32'sh0001_0000;
	localparam logic [DELAY_W-1:0] DELAY_RST = 14'h0000;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// *** design/eval_tick_gen.sv ***
// divider that makes the one-cycle evaluation tick
`timescale 1ns/1ps
module eval_tick_gen #(
	parameter int unsigned PERIOD = 4
) (
	input  wire logic core_clk_in,
	input  wire logic rst_b_in,
	output logic      tick_out
);
	localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} tick_state_t;

	tick_state_t s_q;
	tick_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.tick = (s_q.cnt == LAST);
		if (s_q.cnt == LAST)
			s_d.cnt = '0;
		else
			s_d.cnt = s_q.cnt + 1'b1;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick_out = s_q.tick;
endmodule

// *** design/process_alarm_block.sv ***
// process alarm function block with its apb register file
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module process_alarm_block
	import alarm_pkg::*;
#(
	parameter int unsigned EVAL_CYCLES_P = alarm_pkg::EVAL_CYCLES
) (
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_b_in,
	input  wire alarm_pkg::apb_req_t   apb_req_in,
	output alarm_pkg::apb_rsp_t        apb_rsp_out,
	input  wire alarm_pkg::analog_sig_t monitor_in,
	input  wire logic                  monitor_connected_in,
	input  wire logic                  monitor_remote_lost_in,
	input  wire alarm_pkg::digital_sig_t silence_input_in,
	input  wire alarm_pkg::digital_sig_t clear_input_in,
	input  wire alarm_pkg::digital_sig_t disable_input_in,
	output alarm_pkg::digital_sig_t    alarm_out
);
	import alarm_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		ctrl_t                        ctrl;
		analog_val_t                  high_sp;
		analog_val_t                  low_sp;
		analog_val_t                  hyst;
		logic [DELAY_W-1:0]           delay;
		logic [NAME_WORDS-1:0][31:0]  name;
		logic                         clr_pend;
		logic                         sil_pend;
		logic                         hi;
		logic                         lo;
		out_state_t                   st;
		logic [DCNT_W-1:0]            dcnt;
		digital_sig_t                 out;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ==========================================================
	// helpers
	function automatic logic [32:0] add_chk(input analog_val_t a, input analog_val_t b);
		logic signed [32:0] w;
		w = {a[31], a} + {b[31], b};
		return {w[32] ^ w[31], w[31:0]};
	endfunction

	function automatic logic level_active(input digital_sig_t sig, input logic lvl_high);
		// an input in error never triggers; its level cannot be trusted
		return (sig.err == ERR_NONE) && (sig.on == lvl_high);
	endfunction

	function automatic analog_val_t clamp_power(input analog_sig_t sig);
		analog_val_t v;
		v = sig.value;
		if (sig.unit == UNIT_POWER)
		begin
			if (v > POWER_FULL)
				v = POWER_FULL;
			else if (v < POWER_NONE)
				v = POWER_NONE;
		end
		return v;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr[1:0] == 2'b00) && (addr <= ADDR_NAME_LAST);
	endfunction

	// ==========================================================
	// evaluation tick
	logic tick;

	eval_tick_gen #(
		.PERIOD(EVAL_CYCLES_P)
	) u_tick (
		.core_clk_in(core_clk_in),
		.rst_b_in   (rst_b_in),
		.tick_out   (tick)
	);

	// ==========================================================
	// comparisons
	analog_val_t         val_c;
	logic [32:0]         hi_lim;
	logic [32:0]         lo_lim;
	err_code_t           err_c;
	logic                ok_c;
	logic                en_hi;
	logic                en_lo;
	logic                hi_cond;
	logic                lo_cond;
	logic                hi_ok;
	logic                lo_ok;
	logic                sil_act;
	logic                clr_act;
	logic                dis_act;
	logic                off_c;
	logic [DCNT_W-1:0]   delay_ticks;
	logic                setup;
	logic                access;

	assign val_c   = clamp_power(monitor_in);
	assign hi_lim  = add_chk(s_q.high_sp, analog_val_t'(-s_q.hyst));
	assign lo_lim  = add_chk(s_q.low_sp, s_q.hyst);
	assign en_hi   = (s_q.ctrl.sides != SIDES_LOW);
	assign en_lo   = (s_q.ctrl.sides != SIDES_HIGH);
	assign hi_cond = en_hi && (val_c > s_q.high_sp);
	assign lo_cond = en_lo && (val_c < s_q.low_sp);
	assign hi_ok   = (val_c < $signed(hi_lim[31:0]));
	assign lo_ok   = (val_c > $signed(lo_lim[31:0]));
	assign sil_act = level_active(silence_input_in, s_q.ctrl.sil_lvl) || s_q.sil_pend;
	assign clr_act = level_active(clear_input_in, s_q.ctrl.clr_lvl) || s_q.clr_pend;
	assign dis_act = level_active(disable_input_in, s_q.ctrl.dis_lvl);
	assign off_c   = (s_q.ctrl.atype != ATYPE_PROCESS) || dis_act;
	assign delay_ticks = DCNT_W'(s_q.delay * EVALS_PER_SEC);
	assign setup   = apb_req_in.psel && !apb_req_in.penable;
	assign access  = apb_req_in.psel && apb_req_in.penable && s_q.pready;

	// error priority: missing source, lost remote data, input error, math
	always_comb
	begin
		if (!monitor_connected_in)
			err_c = ERR_NOT_SOURCED;
		else if (monitor_remote_lost_in)
			err_c = ERR_STALE;
		else if (monitor_in.err != ERR_NONE)
			err_c = monitor_in.err;
		else if (hi_lim[32] || lo_lim[32])
			err_c = ERR_MATH;
		else
			err_c = ERR_NONE;
	end
	assign ok_c = (err_c == ERR_NONE);

	// ==========================================================
	// next state
	always_comb
	begin
		logic       trig;
		logic       hi_n;
		logic       lo_n;
		logic       alarm_n;
		out_state_t st_n;
		int unsigned idx;
		trig    = 1'b0;
		hi_n    = s_q.hi;
		lo_n    = s_q.lo;
		alarm_n = 1'b0;
		st_n    = s_q.st;
		idx     = 0;
		s_d     = s_q;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;

		// commands are consumed by the tick that follows them
		if (tick)
		begin
			s_d.clr_pend = 1'b0;
			s_d.sil_pend = 1'b0;
		end

		// apb: data is prepared in setup, so access always ends in one cycle
		if (setup)
		begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !is_mapped(apb_req_in.paddr);
			s_d.prdata  = '0;
			if (apb_req_in.paddr == ADDR_CTRL)
				s_d.prdata = 32'(s_q.ctrl);
			else if (apb_req_in.paddr == ADDR_HIGH_SP)
				s_d.prdata = s_q.high_sp;
			else if (apb_req_in.paddr == ADDR_LOW_SP)
				s_d.prdata = s_q.low_sp;
			else if (apb_req_in.paddr == ADDR_HYST)
				s_d.prdata = s_q.hyst;
			else if (apb_req_in.paddr == ADDR_DELAY)
				s_d.prdata = 32'(s_q.delay);
			else if (apb_req_in.paddr == ADDR_STATUS)
				s_d.prdata = {20'h00000, s_q.out.err, 3'h0, s_q.out.on,
					s_q.st == OUT_SILENCED, s_q.lo, s_q.hi, s_q.hi | s_q.lo};
			else if (apb_req_in.paddr == ADDR_INPUT)
				s_d.prdata = val_c;
			else if (apb_req_in.paddr >= ADDR_NAME0 && is_mapped(apb_req_in.paddr))
			begin
				idx = 32'(apb_req_in.paddr - ADDR_NAME0) >> 2;
				s_d.prdata = s_q.name[idx];
			end
		end

		if (access && apb_req_in.pwrite)
		begin
			if (apb_req_in.paddr == ADDR_CTRL)
				s_d.ctrl = ctrl_t'(apb_req_in.pwdata[9:0]);
			else if (apb_req_in.paddr == ADDR_CMD)
			begin
				// a command landing on the tick cycle survives to the next tick
				if (apb_req_in.pwdata[CMD_CLEAR_BIT])
					s_d.clr_pend = 1'b1;
				if (apb_req_in.pwdata[CMD_SILENCE_BIT])
					s_d.sil_pend = 1'b1;
			end
			else if (apb_req_in.paddr == ADDR_HIGH_SP)
				s_d.high_sp = apb_req_in.pwdata;
			else if (apb_req_in.paddr == ADDR_LOW_SP)
				s_d.low_sp = apb_req_in.pwdata;
			else if (apb_req_in.paddr == ADDR_HYST)
				s_d.hyst = apb_req_in.pwdata;
			else if (apb_req_in.paddr == ADDR_DELAY)
				s_d.delay = apb_req_in.pwdata[DELAY_W-1:0];
			else if (apb_req_in.paddr >= ADDR_NAME0 && is_mapped(apb_req_in.paddr))
			begin
				idx = 32'(apb_req_in.paddr - ADDR_NAME0) >> 2;
				s_d.name[idx] = apb_req_in.pwdata;
			end
		end

		// alarm evaluation happens only on the tick
		if (tick)
		begin
			s_d.out.err = err_c;
			if (off_c)
			begin
				s_d.hi     = 1'b0;
				s_d.lo     = 1'b0;
				s_d.dcnt   = '0;
				s_d.st     = OUT_IDLE;
				s_d.out.on = 1'b0;
			end
			else if (ok_c)
			begin
				// persistence counter saturates at the configured delay
				if (hi_cond || lo_cond)
				begin
					if (s_q.dcnt >= delay_ticks)
						trig = 1'b1;
					else
						s_d.dcnt = s_q.dcnt + 1'b1;
				end
				else
					s_d.dcnt = '0;

				if (trig && hi_cond)
					hi_n = 1'b1;
				else if (s_q.hi && (!en_hi || (hi_ok && (!s_q.ctrl.latch || clr_act))))
					hi_n = 1'b0;
				if (trig && lo_cond)
					lo_n = 1'b1;
				else if (s_q.lo && (!en_lo || (lo_ok && (!s_q.ctrl.latch || clr_act))))
					lo_n = 1'b0;
				alarm_n = hi_n || lo_n;

				case (s_q.st)
					OUT_IDLE:
						if (alarm_n)
							st_n = OUT_ACTIVE;
					OUT_ACTIVE:
						if (!alarm_n)
							st_n = OUT_IDLE;
						else if (s_q.ctrl.sil_en && sil_act)
							st_n = OUT_SILENCED;
					OUT_SILENCED:
						if (!alarm_n)
							st_n = OUT_IDLE;
					default:
						st_n = OUT_IDLE;
				endcase
				s_d.hi     = hi_n;
				s_d.lo     = lo_n;
				s_d.st     = st_n;
				s_d.out.on = (st_n == OUT_ACTIVE) ^ s_q.ctrl.open_on_alarm;
			end
			// on an input error the last decision is held; only the status changes
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			s_q          <= '0;
			s_q.ctrl     <= CTRL_RST;
			s_q.high_sp  <= HIGH_SP_RST;
			s_q.low_sp   <= LOW_SP_RST;
			s_q.hyst     <= HYST_RST;
			s_q.delay    <= DELAY_RST;
			s_q.st       <= OUT_IDLE;
			s_q.out.err  <= ERR_NONE;
		end
		else
			s_q <= s_d;
	end

	// digital output carries only on/off and error, never a unit
	assign alarm_out           = s_q.out;
	assign apb_rsp_out.pready  = s_q.pready;
	assign apb_rsp_out.pslverr = s_q.pslverr;
	assign apb_rsp_out.prdata  = s_q.prdata;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	AST_APB_ONE_WAIT: assert property (setup |=> apb_rsp_out.pready ##1 !apb_rsp_out.pready)
		else $error("apb answer not exactly one cycle after setup");
	AST_OFF_HOLDS_LOW: assert property (tick && (s_q.ctrl.atype != ATYPE_PROCESS) |=> !alarm_out.on && !s_q.hi)
		else $error("type off did not hold output off");
	AST_DISABLE_IS_OFF: assert property (tick && dis_act |=> !alarm_out.on && s_q.st == OUT_IDLE)
		else $error("disable input did not force off");
	AST_NOT_SOURCED: assert property (tick && !monitor_connected_in |=> alarm_out.err == ERR_NOT_SOURCED)
		else $error("missing input not reported");
	AST_STALE: assert property (tick && monitor_connected_in && monitor_remote_lost_in
		|=> alarm_out.err == ERR_STALE)
		else $error("lost remote data not reported");
	AST_ERR_PROPAGATES: assert property (tick && monitor_in.err != ERR_NONE |=> alarm_out.err != ERR_NONE)
		else $error("input error not propagated");
	AST_TICK_ONLY: assert property (!tick |=> $stable(alarm_out) && $stable(s_q.hi) && $stable(s_q.lo))
		else $error("alarm changed between ticks");
	AST_HIGH_TRIPS: assert property (tick && !off_c && ok_c && hi_cond && delay_ticks == '0 |=> s_q.hi)
		else $error("high excursion did not raise alarm");
	AST_SILENCE: assert property (tick && !off_c && ok_c && s_q.st == OUT_ACTIVE && s_q.ctrl.sil_en
		&& sil_act && ((s_q.hi && en_hi && !hi_ok) || (s_q.lo && en_lo && !lo_ok))
		|=> s_q.st == OUT_SILENCED && alarm_out.on == $past(s_q.ctrl.open_on_alarm))
		else $error("silence did not deactivate output");
	AST_LATCH_HOLDS: assert property (tick && !off_c && ok_c && s_q.ctrl.latch && s_q.hi
		&& en_hi && !clr_act |=> s_q.hi)
		else $error("latched alarm cleared without clear");
	AST_MATH: assert property (tick && monitor_connected_in && !monitor_remote_lost_in
		&& monitor_in.err == ERR_NONE && hi_lim[32] |=> alarm_out.err == ERR_MATH)
		else $error("overflowing limit not flagged");
endmodule

// *** sim/signal_source.sv ***
// model of the neighbouring function blocks that feed the alarm receivers
`timescale 1ns/1ps
module signal_source
	import alarm_pkg::*;
(
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_b_in,
	input  wire alarm_pkg::analog_sig_t  mon_set_in,
	input  wire logic                    conn_set_in,
	input  wire logic                    lost_set_in,
	input  wire alarm_pkg::digital_sig_t sil_set_in,
	input  wire alarm_pkg::digital_sig_t clr_set_in,
	input  wire alarm_pkg::digital_sig_t dis_set_in,
	output alarm_pkg::analog_sig_t       monitor_out,
	output logic                         connected_out,
	output logic                         remote_lost_out,
	output alarm_pkg::digital_sig_t      silence_out,
	output alarm_pkg::digital_sig_t      clear_out,
	output alarm_pkg::digital_sig_t      disable_out
);
	logic [31:0] junk_q;

	// ==========================================================
	// transmitters, one cycle behind the bench's settings
	always_ff @(posedge core_clk_in)
	begin
		junk_q <= rst_b_in ? ~junk_q : 32'h5a5a_5a5a;
		// nothing drives an unconnected receiver, so its value must not look sensible
		if (conn_set_in)
			monitor_out <= mon_set_in;
		else
			monitor_out <= '{junk_q, mon_set_in.unit, mon_set_in.err};
		connected_out <= conn_set_in;
		remote_lost_out <= lost_set_in;
		silence_out <= sil_set_in;
		clear_out <= clr_set_in;
		disable_out <= dis_set_in;
	end
endmodule

// *** sim/tb.sv ***
// self-checking bench of the process alarm block
`timescale 1ns/1ps
module tb;
	import alarm_pkg::*;
	localparam int unsigned EVC = 8;
	logic         core_clk_in;
	logic         rst_b_in;
	apb_req_t     req;
	apb_rsp_t     rsp;
	analog_sig_t  mon_set;
	analog_sig_t  mon;
	logic         conn_set;
	logic         lost_set;
	logic         conn;
	logic         lost;
	digital_sig_t sil_set;
	digital_sig_t clr_set;
	digital_sig_t dis_set;
	digital_sig_t silence_input;
	digital_sig_t clr;
	digital_sig_t dis;
	digital_sig_t alarm;
	logic [65:0]  notes[$];
	logic [65:0]  note;
	logic [31:0]  rnd_q;
	logic [31:0]  w[5];
	int           err_count;
	int           n_checks;
	int           i;

	signal_source src_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .mon_set_in(mon_set),
		.conn_set_in(conn_set), .lost_set_in(lost_set), .sil_set_in(sil_set), .clr_set_in(clr_set),
		.dis_set_in(dis_set), .monitor_out(mon), .connected_out(conn), .remote_lost_out(lost),
		.silence_out(silence_input), .clear_out(clr), .disable_out(dis));

	process_alarm_block #(.EVAL_CYCLES_P(EVC)) dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.apb_req_in(req), .apb_rsp_out(rsp), .monitor_in(mon), .monitor_connected_in(conn),
		.monitor_remote_lost_in(lost), .silence_input_in(silence_input), .clear_input_in(clr),
		.disable_input_in(dis), .alarm_out(alarm));

	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		rnd_q = rnd_q ^ (rnd_q << 13);
		rnd_q = rnd_q ^ (rnd_q >> 17);
		rnd_q = rnd_q ^ (rnd_q << 5);
		return rnd_q;
	endfunction

	function automatic logic [31:0] cw(alarm_type_t t, sides_t s, logic lat, logic sen, logic opn, logic slv);
		ctrl_t c;
		c = '{1'b1, 1'b1, slv, opn, sen, lat, s, t};
		return 32'(c);
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one apb transfer; the watcher below compares the answer against the note
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp,
		input logic [32:0] msk);
		int k;
		notes.push_back({msk, exp});
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk_in);
		req.penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge core_clk_in);
			if (rsp.pready === 1'b1)
				break;
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// one idle edge, so the next call never overwrites the release in the same step
		@(posedge core_clk_in);
		if (k == 20)
		begin
			err_count++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e}, 33'h1_ffff_ffff);
	endtask

	task automatic st(input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, ADDR_STATUS, 32'h0, {1'b0, e & m}, {1'b1, m});
	endtask

	// three ticks: the sampling tick, the update and a margin for the source model
	task automatic settle(input logic [31:0] v);
		mon_set.value <= v;
		repeat (3 * EVC) @(posedge core_clk_in);
	endtask

	task automatic norm();
		settle(32'h0002_0000 + xs() % 32'h0050_0000);
	endtask

	always @(posedge core_clk_in)
		if (rst_b_in === 1'b1 && rsp.pready === 1'b1)
		begin
			note = notes.pop_front();
			check({rsp.pslverr, rsp.prdata} & note[65:33], note[32:0]);
		end

	// ==========================================================
	// main sequence
	initial
	begin
		rst_b_in = 1'b0;
		req = '0;
		rnd_q = 32'd53;
		mon_set = '{32'sh0032_0000, UNIT_PROCESS, ERR_NONE};
		conn_set = 1'b1;
		lost_set = 1'b0;
		sil_set = '{1'b0, ERR_NONE};
		clr_set = '{1'b0, ERR_NONE};
		dis_set = '{1'b0, ERR_NONE};
		err_count = 0;
		n_checks = 0;
		repeat (4) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		@(posedge core_clk_in);
		check({28'h0, alarm}, 33'h0);
		rd(ADDR_CTRL, 32'h380);
		rd(ADDR_HIGH_SP, 32'h0064_0000);
		rd(ADDR_HYST, 32'h0001_0000);
		rd(ADDR_DELAY, 32'h0);
		apb(1'b0, 8'h34, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
		apb(1'b0, 8'h02, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
		for (i = 0; i < 5; i++)
		begin
			w[i] = xs();
			wr(ADDR_NAME0 + 8'(4 * i), w[i]);
		end
		for (i = 0; i < 5; i++)
			rd(ADDR_NAME0 + 8'(4 * i), w[i]);
		settle(32'h0065_0000);
		st(32'h0, 32'hf1f);
		wr(ADDR_CTRL, cw(alarm_type_t'(2'h3), SIDES_BOTH, 1'b0, 1'b0, 1'b0, 1'b1));
		settle(32'h0065_0000);
		st(32'h0, 32'hf1f);
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_BOTH, 1'b0, 1'b0, 1'b0, 1'b1));
		settle(32'h0065_0000);
		st(32'h13, 32'hf1f);
		check({28'h0, alarm}, {28'h0, 1'b1, ERR_NONE});
		settle(32'h0063_8000);
		st(32'h13, 32'hf1f);
		settle(32'h0062_0000);
		st(32'h0, 32'hf1f);
		settle(32'hffff_0000);
		st(32'h15, 32'hf1f);
		norm();
		// ==========================================================
		// sides: the ignored comparison must not alarm, the kept one must
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_HIGH, 1'b0, 1'b0, 1'b0, 1'b1));
		settle(32'hffff_0000);
		st(32'h0, 32'hf1f);
		settle(32'h0065_0000);
		st(32'h13, 32'hf1f);
		norm();
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_LOW, 1'b0, 1'b0, 1'b0, 1'b1));
		settle(32'h0065_0000);
		st(32'h0, 32'hf1f);
		settle(32'hffff_0000);
		st(32'h15, 32'hf1f);
		norm();
		// ==========================================================
		// silence with an active-low receiver
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_BOTH, 1'b0, 1'b1, 1'b0, 1'b0));
		sil_set.on <= 1'b1;
		settle(32'h0065_0000);
		st(32'h13, 32'hf1f);
		sil_set.on <= 1'b0;
		settle(32'h0065_0000);
		st(32'h0b, 32'hf1f);
		check({28'h0, alarm}, 33'h0);
		norm();
		st(32'h0, 32'hf1f);
		sil_set.on <= 1'b1;
		settle(32'h0065_0000);
		wr(ADDR_CMD, 32'h2);
		settle(32'h0065_0000);
		st(32'h0b, 32'hf1f);
		norm();
		// ==========================================================
		// latching, clear receiver and clear command
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_BOTH, 1'b1, 1'b0, 1'b0, 1'b1));
		clr_set.on <= 1'b1;
		settle(32'h0065_0000);
		st(32'h11, 32'h11);
		clr_set.on <= 1'b0;
		norm();
		st(32'h11, 32'h11);
		clr_set.on <= 1'b1;
		norm();
		st(32'h0, 32'h11);
		clr_set.on <= 1'b0;
		settle(32'h0065_0000);
		norm();
		wr(ADDR_CMD, 32'h1);
		norm();
		st(32'h0, 32'h11);
		// ==========================================================
		// open on alarm, then disable receiver
		wr(ADDR_CTRL, cw(ATYPE_PROCESS, SIDES_BOTH, 1'b0, 1'b0, 1'b1, 1'b1));
		norm();
		check({28'h0, alarm}, {28'h0, 1'b1, ERR_NONE});
		settle(32'h0065_0000);
		st(32'h03, 32'hf1f);
		dis_set.on <= 1'b1;
		settle(32'h0065_0000);
		st(32'h0, 32'hf1f);
		check({28'h0, alarm}, 33'h0);
		dis_set.on <= 1'b0;
		norm();
		// ==========================================================
		// error status passes to the output
		mon_set.err <= ERR_OPEN;
		norm();
		check({29'h0, alarm.err}, {29'h0, ERR_OPEN});
		mon_set.err <= ERR_NONE;
		conn_set <= 1'b0;
		norm();
		st(32'h800, 32'hf00);
		conn_set <= 1'b1;
		lost_set <= 1'b1;
		norm();
		check({29'h0, alarm.err}, {29'h0, ERR_STALE});
		lost_set <= 1'b0;
		norm();
		st(32'h0, 32'hf00);
		// ==========================================================
		// power is clamped to full power before comparing
		wr(ADDR_HIGH_SP, 32'h0096_0000);
		mon_set.unit <= UNIT_POWER;
		settle(32'h00c8_0000);
		rd(ADDR_INPUT, 32'h0064_0000);
		st(32'h0, 32'h1);
		mon_set.unit <= UNIT_PROCESS;
		wr(ADDR_HIGH_SP, 32'h8000_0000);
		norm();
		st(32'ha00, 32'hf00);
		wr(ADDR_HIGH_SP, 32'h0064_0000);
		// ==========================================================
		// one second delay: a short excursion restarts the count
		wr(ADDR_DELAY, 32'h1);
		settle(32'h0065_0000);
		repeat (100 * EVC) @(posedge core_clk_in);
		norm();
		settle(32'h0065_0000);
		repeat (900 * EVC) @(posedge core_clk_in);
		st(32'h0, 32'h1);
		repeat (200 * EVC) @(posedge core_clk_in);
		st(32'h1, 32'h1);
		stop_test();
	end
endmodule
